// File: spcfg_host.sv
`timescale 1ns/100ps
module spcfg_host (
  input  wire logic        clk_sys,
  output logic             frame_done = 0, frame_start = 0,
  output logic             frame_crc_present = 0, frame_crc_ok = 0,
  output logic [15:0]      frame_word = 0);
  // Word and boundary move one cycle apart, as a real decoder would
  task automatic send(input logic [15:0] w, input logic p, k);
    frame_word = w;
    frame_done = 1;
    frame_crc_present = p;
    frame_crc_ok = k;
    @(posedge clk_sys) #1;
    frame_done = 0;
    frame_word = ~w;
    frame_start = 1;
    @(posedge clk_sys) #1;
    frame_start = 0;
  endtask
endmodule // spcfg_host

// File: spcfg_pkg.sv
package spcfg_pkg;
  // Register addressing
  localparam logic [2:0]  REG_ADDR_SAMPLING = 3'h1;
  localparam logic [15:0] SAMPLING_RESET    = 16'h0000;
  // Command word layout
  localparam int WR_FLAG_BIT  = 15;
  localparam int SEL_HI       = 14;
  localparam int SEL_LO       = 12;
  // Field positions inside the register word
  localparam int ADDR_HI      = 15;
  localparam int ADDR_LO      = 12;
  localparam int RSVD_HI      = 11;
  localparam int RSVD_LO      = 10;
  localparam int AVG_EN_BIT   = 9;
  localparam int RATIO_HI     = 8;
  localparam int RATIO_LO     = 6;
  localparam int IN_CHK_BIT   = 5;
  localparam int OUT_CHK_BIT  = 4;
  localparam int FLAG_SEL_BIT = 3;
  localparam int LOW_HI       = 2;
  localparam int LOW_LO       = 0;
  // Ratio codes
  localparam logic [2:0] RATIO_X2 = 3'h1;
  localparam logic [2:0] RATIO_X4 = 3'h2;
  localparam logic [2:0] RATIO_X8 = 3'h3;

  typedef enum logic [1:0] {
    SPCFG_AVG_OFF,
    SPCFG_AVG_2,
    SPCFG_AVG_4,
    SPCFG_AVG_8
  } spcfg_ratio_e;

  // Settings applied to the rest of the device
  typedef struct packed {
    logic         avg_active;
    spcfg_ratio_e ratio;
    logic         in_check;
    logic         out_check;
    logic         flag_on_second;
  } spcfg_apply_s;
endpackage

// File: spcfg_sampling_config.sv
`timescale 1ns/100ps
// What this block does
// - Register lives at address 1; its stored bits reset to zero, so it reads back 0x1000.
// - Read-back shows the register address in bits 15 to 12.
// - Bit 9 turns rolling-average oversampling on or off.
// - Bits 8 to 6 pick one ratio for both channels while averaging.
// - Ratio codes 1,2,3 mean x2,x4,x8; all others disable averaging.
// - Bit 5 enables CRC checking of serial input frames.
// - Write needing CRC without a valid one changes nothing.
// - Clearing an active input check also needs a valid CRC.
// - Bit 4 enables CRC generation on both output lanes.
// - Bit 3 makes the second pin an alert flag instead of data.
// - Flag select counts only while single-lane output is set.
// - Write flag set loads low ten bits into the selected register; bits 11 and 10 stay zero.
// - Single-lane setting sends conversion data on the first lane only.
module spcfg_sampling_config #(
  // Command and register geometry
  parameter int WORD_W = 16,
  parameter int DATA_W = 12,
  parameter int SEL_W  = 3
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Decoded 16-bit frame from the serial input line
  input  wire logic                  frame_done,
  input  wire logic [15:0]           frame_word,
  input  wire logic                  frame_crc_present,
  input  wire logic                  frame_crc_ok,
  // Frame boundary and second-register setting
  input  wire logic                  frame_start,
  input  wire logic                  single_lane_select,
  // Register contents and effective settings
  output logic [15:0]                sampling_config,
  output logic                       read_request,
  output spcfg_pkg::spcfg_apply_s    applied,
  output logic                       second_lane_data,
  output logic                       first_lane_only,
  output logic                       write_rejected
);

  logic [11:0] store;
  logic [11:0] next_store;
  logic        hit;
  logic        is_write;
  logic        is_read;
  logic        needs_crc;
  logic        crc_good;
  logic        write_ok;
  logic        write_bad;
  logic        next_write_rejected;
  logic        next_read_request;
  logic        next_first_lane_only;
  logic        next_second_lane_data;
  logic [3:0]  addr_nibble;
  logic [2:0]  ratio_code;
  logic        flag_bit;
  spcfg_pkg::spcfg_apply_s next_applied;

  // The field map is fixed by the command format; other widths cannot be served
  if (WORD_W != 16) begin : g_word_check
    $error("spcfg_sampling_config: WORD_W must be 16");
  end
  if (DATA_W != 12) begin : g_data_check
    $error("spcfg_sampling_config: DATA_W must be 12");
  end
  if (SEL_W != 3) begin : g_sel_check
    $error("spcfg_sampling_config: SEL_W must be 3");
  end

  // Command decode
  assign hit = frame_word[spcfg_pkg::SEL_HI:spcfg_pkg::SEL_LO]
               == spcfg_pkg::REG_ADDR_SAMPLING;
  assign is_write = frame_done && frame_word[spcfg_pkg::WR_FLAG_BIT] && hit;
  assign is_read  = !frame_word[spcfg_pkg::WR_FLAG_BIT] && hit;

  // Either an active check or an attempt to turn it on demands a CRC
  assign needs_crc = store[spcfg_pkg::IN_CHK_BIT - spcfg_pkg::LOW_LO]
                     | frame_word[spcfg_pkg::IN_CHK_BIT];
  assign crc_good  = frame_crc_present & frame_crc_ok;

  // Gate sits ahead of the store so a refused frame touches no bit at all
  assign write_ok  = is_write && (!needs_crc || crc_good);
  assign write_bad = is_write && needs_crc && !crc_good;

  // Next register contents; reserved bits never stored
  always_comb begin
    next_store = store;
    if (write_ok) begin
      next_store = {2'h0, frame_word[spcfg_pkg::AVG_EN_BIT:spcfg_pkg::LOW_LO]};
    end
  end

  // Read request holds until the next decoded frame (frame_done) replaces it
  always_comb begin
    next_read_request = read_request;
    if (frame_done) begin
      next_read_request = is_read;
    end
  end

  // One-cycle pulse; it clears on the next clock without help
  assign next_write_rejected = write_bad;

  // Register write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      store <= spcfg_pkg::SAMPLING_RESET[11:0];
    end else begin
      store <= next_store;
    end
  end

  // Rejection pulse for a write lacking the required CRC
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_rejected <= 1'b0;
    end else begin
      write_rejected <= next_write_rejected;
    end
  end

  // Read request is answered in the next frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      read_request <= 1'b0;
    end else begin
      read_request <= next_read_request;
    end
  end

  // Read-back word built per bit: address nibble, zeroed reserved pair, stored bits
  assign addr_nibble = {1'b0, spcfg_pkg::REG_ADDR_SAMPLING};
  for (genvar b = 0; b < 16; b++) begin : g_readback
    if (b >= spcfg_pkg::ADDR_LO) begin : g_addr
      assign sampling_config[b] = addr_nibble[b - spcfg_pkg::ADDR_LO];
    end else if (b >= spcfg_pkg::RSVD_LO) begin : g_rsvd
      assign sampling_config[b] = 1'b0;
    end else begin : g_store
      assign sampling_config[b] = store[b];
    end
  end

  assign ratio_code = store[spcfg_pkg::RATIO_HI:spcfg_pkg::RATIO_LO];
  assign flag_bit   = store[spcfg_pkg::FLAG_SEL_BIT];

  always_comb begin
    next_applied            = applied;
    next_applied.in_check   = store[spcfg_pkg::IN_CHK_BIT];
    next_applied.out_check  = store[spcfg_pkg::OUT_CHK_BIT];
    next_applied.flag_on_second = flag_bit && single_lane_select;
    unique case (ratio_code)
      spcfg_pkg::RATIO_X2: next_applied.ratio = spcfg_pkg::SPCFG_AVG_2;
      spcfg_pkg::RATIO_X4: next_applied.ratio = spcfg_pkg::SPCFG_AVG_4;
      spcfg_pkg::RATIO_X8: next_applied.ratio = spcfg_pkg::SPCFG_AVG_8;
      default:             next_applied.ratio = spcfg_pkg::SPCFG_AVG_OFF;
    endcase
    // One ratio shared by both channels
    next_applied.avg_active = store[spcfg_pkg::AVG_EN_BIT] &&
                              (next_applied.ratio != spcfg_pkg::SPCFG_AVG_OFF);
  end

  // Settings latch at frame start so a frame never sees a mid-frame change
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      applied <= '0;
    end else if (frame_start) begin
      applied <= next_applied;
    end
  end

  // Lane routing also changes only at a frame boundary, never mid-word
  always_comb begin
    next_first_lane_only  = first_lane_only;
    next_second_lane_data = second_lane_data;
    if (frame_start) begin
      next_first_lane_only  = single_lane_select;
      next_second_lane_data = !single_lane_select;
    end
  end

  // Two-lane output is the reset state, so the second pin starts as data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_lane_only  <= 1'b0;
      second_lane_data <= 1'b1;
    end else begin
      first_lane_only  <= next_first_lane_only;
      second_lane_data <= next_second_lane_data;
    end
  end

endmodule // spcfg_sampling_config

// File: spcfg_sampling_config_chk.sv
`timescale 1ns/100ps
module spcfg_sampling_config_chk (
  input wire logic clk_sys, rst, frame_done, frame_crc_present, frame_crc_ok, frame_start,
  input wire logic single_lane_select, read_request, write_rejected,
  input wire logic first_lane_only, second_lane_data,
  input wire logic [15:0] frame_word, sampling_config,
  input wire spcfg_pkg::spcfg_apply_s applied);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire wr1 = frame_done && frame_word[15:12] == 4'h9;
  wire s9 = sampling_config[9];
  a_reset_value: assert property ($fell(rst) |-> sampling_config == 16'h1000) else $error("rst");
  a_addr_rsvd: assert property (sampling_config[15:10] == 6'h04) else $error("addr");
  a_write_load: assert property (wr1 && !frame_word[5] && !sampling_config[5]
    |=> sampling_config[9:0] == $past(frame_word[9:0])) else $error("load");
  a_crc_refuse: assert property (wr1 && (frame_word[5] || sampling_config[5])
    && !(frame_crc_present && frame_crc_ok) |=> write_rejected && $stable(sampling_config))
    else $error("crc");
  a_apply_hold: assert property (!frame_start |=> $stable(applied)) else $error("hold");
  a_crc_apply: assert property (frame_start |=> applied.in_check == $past(sampling_config[5])
    && applied.out_check == $past(sampling_config[4])) else $error("chk");
  a_avg_on: assert property (frame_start && s9 && sampling_config[8:6] inside {[1:3]}
    |=> applied.avg_active && applied.ratio == $past(sampling_config[7:6])) else $error("avg");
  a_avg_off: assert property (frame_start && (!s9 || sampling_config[8:6] == 0
    || sampling_config[8]) |=> !applied.avg_active) else $error("off");
  a_flag_sel: assert property (frame_start |=> applied.flag_on_second ==
    ($past(sampling_config[3]) && $past(single_lane_select))) else $error("flag");
  a_lane_route: assert property (frame_start |=>
    first_lane_only == $past(single_lane_select) && second_lane_data == !$past(single_lane_select))
    else $error("lane");
  a_read_flag: assert property (frame_done |=>
    read_request == ($past(frame_word[15:12]) == 4'h1)) else $error("rd");
endmodule // spcfg_sampling_config_chk

// File: spcfg_sampling_config_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; $display("ERROR %0t: got %h exp %h", $time, a, e); end end
bind spcfg_sampling_config spcfg_sampling_config_chk chk_u (.*);
module spcfg_sampling_config_tb_top;
  logic clk_sys = 0, rst = 1, single_lane_select = 0, p, k;
  logic frame_done, frame_start, frame_crc_present, frame_crc_ok;
  logic [15:0] frame_word, sampling_config, cur, w, e;
  logic read_request, second_lane_data, first_lane_only, write_rejected;
  logic lane_exp = 1'b0;
  spcfg_pkg::spcfg_apply_s applied;
  logic [31:0] lf = 32'hCDDC;
  logic [15:0] q[$];
  int failures = 0, tests_run = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  spcfg_sampling_config dut_u (.*);
  spcfg_host host_u (.*);
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (frame_start && q.size() > 0) begin
      e = q.pop_front();
      `CHK(sampling_config, e)
    end
    if (frame_start) begin
      `CHK(first_lane_only, lane_exp)
      `CHK(second_lane_data, !lane_exp)
      lane_exp = single_lane_select;
    end
    if (cyc > 1000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    cur = 16'h1000;
    repeat (8) @(posedge clk_sys);
    #1 rst = 0;
    for (int i = 0; i < 300; i++) begin
      lf = nx(lf);
      w = {lf[15], lf[16] ? 3'h1 : lf[14:12], lf[11:0]};
      p = lf[17];
      k = lf[18] | lf[19];
      // Refused writes keep the register as it was
      if (w[15:12] == 4'h9 && (!(cur[5] | w[5]) || (p && k))) cur[9:0] = w[9:0];
      q.push_back(cur);
      host_u.send(w, p, k);
      single_lane_select = lf[20];
    end
    repeat (3) @(posedge clk_sys);
    end_sim();
  end
endmodule // spcfg_sampling_config_tb_top
